// ### stu_map.vh
`ifndef STU_MAP_VH
`define STU_MAP_VH
// Register indices
`define STU_REG_CTRL_AUX 3'h0
`define STU_REG_CTRL_CORE 3'h1
`define STU_REG_AUX 3'h2
`define STU_REG_CORE 3'h3
`define STU_REG_CAPTURE_RELOAD_REG 3'h4
`define STU_REG_CAPCTRL 3'h5
`define STU_REG_STATUS 3'h6
// Timer control fields
`define STU_TC_PRE_LSB 0
`define STU_TC_PRE_MSB 2
`define STU_TC_SRC_LSB 3
`define STU_TC_SRC_MSB 4
`define STU_TC_RUN 5
`define STU_TC_DOWN 6
`define STU_TC_EXTDIR 7
`define STU_TC_EDGE_LSB 8
`define STU_TC_EDGE_MSB 9
`define STU_TC_RELOAD 10
`define STU_TC_OUTEN 11
// Capture control fields
`define STU_CC_PIN_EDGE_LSB 0
`define STU_CC_PIN_EDGE_MSB 1
`define STU_CC_CLR 2
`define STU_CC_UP_CNT 3
`define STU_CC_UP_DIR 4
`define STU_CC_USE_PIN 5
// Clock sources
`define STU_SRC_PRESCALE 2'h0
`define STU_SRC_PIN 2'h1
`define STU_SRC_TOGGLE 2'h2
// Reset values
`define STU_RST_CTRL 16'h0000
`define STU_RST_CAPCTRL 16'h0000
// Fastest prescaled tick in system clocks
`define STU_MIN_DIV 2
`endif

// ### stu_sync_edge.v
`timescale 1ns/1ps
module stu_sync_edge (
    input wire clk, // System clock
    input wire rst_n, // Sync reset
    input wire pin, // Asynchronous-ish pin
    output wire level, // Synchronised level
    output wire rise, // One-cycle rising pulse
    output wire fall // One-cycle falling pulse
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    always @(posedge clk) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    assign level = s2_reg;
    assign rise = s2_reg & ~s3_reg;
    assign fall = ~s2_reg & s3_reg;
endmodule

// ### stu_prescaler.v
`timescale 1ns/1ps
`include "stu_map.vh"
module stu_prescaler (
    input wire clk, // System clock
    input wire rst_n, // Sync reset
    input wire [2:0] sel, // Divide by 2^(sel+1)
    output reg tick // One-cycle count enable
);
    reg [7:0] cnt_reg;
    wire [7:0] cnt_next;
    wire [7:0] last;
    wire [31:0] span;
    assign cnt_next = cnt_reg + 8'h01;
    // Widest span is 256 clocks, so the low byte always holds it
    assign span = (32'h0000_0001 << sel) * `STU_MIN_DIV - 32'h0000_0001;
    assign last = span[7:0];
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            tick <= 1'b0;
        end else if (cnt_reg >= last) begin
            cnt_reg <= 8'h00;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            tick <= 1'b0;
        end
    end
endmodule

// ### stu_timer_unit.v
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "stu_map.vh"
module stu_timer_unit (
    input wire clk, // System clock, 50 MHz
    input wire rst_n, // Sync reset, active low
    input wire [2:0] addr, // Register index
    input wire [15:0] wdata, // Write data
    input wire wr, // Write strobe
    input wire rd, // Read strobe
    output reg [15:0] rdata, // Read data, cycle after rd
    input wire aux_count_pin, // Aux external clock
    input wire core_count_pin, // Core external clock
    input wire aux_dir_pin, // Aux direction control pin
    input wire core_dir_pin, // Core direction control pin
    input wire capture_input_pin, // Capture trigger pin
    input wire upstream_count_input, // First unit core count input
    input wire upstream_direction_input, // First unit core direction input
    output reg toggle_latch_output_pin, // Toggle latch output
    output reg core_event_out // Over/underflow pulse to unit two
);
    ////////////////////////////////////////////////////////////////////////
    // two counters, one capture/reload
    reg [15:0] ctrl_aux_reg;
    reg [15:0] ctrl_core_reg;
    reg [15:0] capctrl_reg;
    reg [15:0] aux_reg;
    reg [15:0] core_reg;
    reg [15:0] capture_reload_reg_reg;
    reg overflow_toggle_latch;
    reg toggle_prev_reg;
    wire [2:0] aux_pre;
    wire [2:0] core_pre;
    wire aux_tick_pre;
    wire core_tick_pre;
    wire aux_cnt_lvl;
    wire aux_cnt_r;
    wire aux_cnt_f;
    wire core_cnt_lvl;
    wire core_cnt_r;
    wire core_cnt_f;
    wire aux_dir_lvl;
    wire core_dir_lvl;
    wire cap_lvl;
    wire cap_r;
    wire cap_f;
    wire up_cnt_lvl;
    wire up_cnt_r;
    wire up_cnt_f;
    wire up_dir_r;
    wire up_dir_f;
    wire wr_aux;
    wire wr_core;
    wire wr_capture_reload_reg;
    wire wr_status;
    wire [15:0] status_word;
    reg [15:0] core_next;
    reg [15:0] aux_next;
    reg [15:0] capture_reload_reg_next;
    reg latch_next;

    // Edge selection: bit0 rising, bit1 falling
    function edge_hit;
        input [1:0] sel;
        input r;
        input f;
        begin
            edge_hit = (sel[0] & r) | (sel[1] & f);
        end
    endfunction

    // Count step: source, tick, pin edges, toggle edge
    function count_en;
        input [15:0] ctrl;
        input tick;
        input r;
        input f;
        input tog;
        begin
            case (ctrl[`STU_TC_SRC_MSB:`STU_TC_SRC_LSB])
                `STU_SRC_PRESCALE: count_en = tick;
                `STU_SRC_PIN: count_en = edge_hit(ctrl[`STU_TC_EDGE_MSB:`STU_TC_EDGE_LSB], r, f);
                `STU_SRC_TOGGLE: count_en = tog;
                default: count_en = 1'b0;
            endcase
        end
    endfunction

    // Direction: software bit, or pin level when enabled
    function is_down;
        input [15:0] ctrl;
        input pin_lvl;
        begin
            is_down = ctrl[`STU_TC_EXTDIR] ? pin_lvl : ctrl[`STU_TC_DOWN];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    stu_sync_edge u_aux_cnt (
        .clk(clk),
        .rst_n(rst_n),
        .pin(aux_count_pin),
        .level(aux_cnt_lvl),
        .rise(aux_cnt_r),
        .fall(aux_cnt_f)
    );
    stu_sync_edge u_core_cnt (
        .clk(clk),
        .rst_n(rst_n),
        .pin(core_count_pin),
        .level(core_cnt_lvl),
        .rise(core_cnt_r),
        .fall(core_cnt_f)
    );
    // Direction pins act as levels only
    stu_sync_edge u_aux_dir (
        .clk(clk),
        .rst_n(rst_n),
        .pin(aux_dir_pin),
        .level(aux_dir_lvl),
        .rise(),
        .fall()
    );
    stu_sync_edge u_core_dir (
        .clk(clk),
        .rst_n(rst_n),
        .pin(core_dir_pin),
        .level(core_dir_lvl),
        .rise(),
        .fall()
    );
    stu_sync_edge u_cap (
        .clk(clk),
        .rst_n(rst_n),
        .pin(capture_input_pin),
        .level(cap_lvl),
        .rise(cap_r),
        .fall(cap_f)
    );
    stu_sync_edge u_up_cnt (
        .clk(clk),
        .rst_n(rst_n),
        .pin(upstream_count_input),
        .level(up_cnt_lvl),
        .rise(up_cnt_r),
        .fall(up_cnt_f)
    );
    stu_sync_edge u_up_dir (
        .clk(clk),
        .rst_n(rst_n),
        .pin(upstream_direction_input),
        .level(),
        .rise(up_dir_r),
        .fall(up_dir_f)
    );

    ////////////////////////////////////////////////////////////////////////
    // prescalers
    assign aux_pre = ctrl_aux_reg[`STU_TC_PRE_MSB:`STU_TC_PRE_LSB];
    assign core_pre = ctrl_core_reg[`STU_TC_PRE_MSB:`STU_TC_PRE_LSB];
    stu_prescaler u_aux_pre (
        .clk(clk),
        .rst_n(rst_n),
        .sel(aux_pre),
        .tick(aux_tick_pre)
    );
    stu_prescaler u_core_pre (
        .clk(clk),
        .rst_n(rst_n),
        .sel(core_pre),
        .tick(core_tick_pre)
    );

    ////////////////////////////////////////////////////////////////////////
    wire core_step;
    wire core_down;
    wire core_wrap;
    wire tog_edge;
    wire aux_step;
    wire aux_down;
    wire cap_trig;

    assign core_step = ctrl_core_reg[`STU_TC_RUN] &
        count_en(ctrl_core_reg, core_tick_pre, core_cnt_r, core_cnt_f, 1'b0);
    assign core_down = is_down(ctrl_core_reg, core_dir_lvl);
    assign core_wrap = core_step & (core_down ? (core_reg == 16'h0000) : (core_reg == 16'hFFFF));

    assign tog_edge = overflow_toggle_latch ^ toggle_prev_reg;
    assign aux_step = ctrl_aux_reg[`STU_TC_RUN] &
        count_en(ctrl_aux_reg, aux_tick_pre, aux_cnt_r, aux_cnt_f, tog_edge);
    assign aux_down = is_down(ctrl_aux_reg, aux_dir_lvl);

    assign cap_trig = (capctrl_reg[`STU_CC_USE_PIN] &
            edge_hit(capctrl_reg[`STU_CC_PIN_EDGE_MSB:`STU_CC_PIN_EDGE_LSB], cap_r, cap_f)) |
        (capctrl_reg[`STU_CC_UP_CNT] & (up_cnt_r | up_cnt_f)) |
        (capctrl_reg[`STU_CC_UP_DIR] & (up_dir_r | up_dir_f));

    // Write decode
    assign wr_aux = wr && (addr == `STU_REG_AUX);
    assign wr_core = wr && (addr == `STU_REG_CORE);
    assign wr_capture_reload_reg = wr && (addr == `STU_REG_CAPTURE_RELOAD_REG);
    assign wr_status = wr && (addr == `STU_REG_STATUS);

    // Core next value; software write wins over counting
    always @* begin
        core_next = core_reg;
        if (wr_core) begin
            core_next = wdata;
        end else if (core_wrap && ctrl_core_reg[`STU_TC_RELOAD]) begin
            core_next = capture_reload_reg_reg;
        end else if (core_step) begin
            core_next = core_down ? core_reg - 16'h0001 : core_reg + 16'h0001;
        end
    end

    // toggle on wrap; a wrap also flips a written value
    always @* begin
        latch_next = overflow_toggle_latch;
        if (wr_status) begin
            latch_next = wdata[0] ^ core_wrap;
        end else if (core_wrap) begin
            latch_next = ~overflow_toggle_latch;
        end
    end

    // Aux next value; clear beats software write
    always @* begin
        aux_next = aux_reg;
        if (cap_trig && capctrl_reg[`STU_CC_CLR]) begin
            aux_next = 16'h0000;
        end else if (wr_aux) begin
            aux_next = wdata;
        end else if (aux_step) begin
            aux_next = aux_down ? aux_reg - 16'h0001 : aux_reg + 16'h0001;
        end
    end

    // Capture beats software write
    always @* begin
        capture_reload_reg_next = capture_reload_reg_reg;
        if (cap_trig) begin
            capture_reload_reg_next = aux_reg;
        end else if (wr_capture_reload_reg) begin
            capture_reload_reg_next = wdata;
        end
    end

    // Status: synced levels read-only, bit0 is the toggle latch
    assign status_word = {
        11'h000,
        cap_lvl,
        up_cnt_lvl,
        core_cnt_lvl,
        aux_cnt_lvl,
        overflow_toggle_latch
    };

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always @(posedge clk) begin
        if (!rst_n) begin
            ctrl_aux_reg <= `STU_RST_CTRL;
            ctrl_core_reg <= `STU_RST_CTRL;
            capctrl_reg <= `STU_RST_CAPCTRL;
        end else if (wr) begin
            case (addr)
                `STU_REG_CTRL_AUX: ctrl_aux_reg <= wdata;
                `STU_REG_CTRL_CORE: ctrl_core_reg <= wdata;
                `STU_REG_CAPCTRL: capctrl_reg <= wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core timer and toggle latch; a core write wins over counting, a wrap still flips a written latch
    always @(posedge clk) begin
        if (!rst_n) begin
            core_reg <= 16'h0000;
            overflow_toggle_latch <= 1'b0;
            toggle_prev_reg <= 1'b0;
            core_event_out <= 1'b0;
            toggle_latch_output_pin <= 1'b0;
        end else begin
            toggle_prev_reg <= overflow_toggle_latch;
            core_event_out <= core_wrap;
            toggle_latch_output_pin <= ctrl_core_reg[`STU_TC_OUTEN] & overflow_toggle_latch;
            core_reg <= core_next;
            overflow_toggle_latch <= latch_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Aux timer and capture/reload register
    always @(posedge clk) begin
        if (!rst_n) begin
            aux_reg <= 16'h0000;
            capture_reload_reg_reg <= 16'h0000;
        end else begin
            capture_reload_reg_reg <= capture_reload_reg_next;
            aux_reg <= aux_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port; unmapped reads return zero
    always @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                `STU_REG_CTRL_AUX: rdata <= ctrl_aux_reg;
                `STU_REG_CTRL_CORE: rdata <= ctrl_core_reg;
                `STU_REG_AUX: rdata <= aux_reg;
                `STU_REG_CORE: rdata <= core_reg;
                `STU_REG_CAPTURE_RELOAD_REG: rdata <= capture_reload_reg_reg;
                `STU_REG_CAPCTRL: rdata <= capctrl_reg;
                `STU_REG_STATUS: rdata <= status_word;
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule

// ### stu_timer_checker.sv
`timescale 1ns/1ps
module stu_timer_checker (
    input wire clk, // Clock
    input wire rst_n, // Reset
    input wire [2:0] addr, // Index
    input wire [15:0] wdata, // Wdata
    input wire wr, // Write
    input wire rd, // Read
    input wire [15:0] rdata, // Rdata
    input wire aux_count_pin, // Aux clk
    input wire core_count_pin, // Core clk
    input wire aux_dir_pin, // Aux dir
    input wire core_dir_pin, // Core dir
    input wire capture_input_pin, // Capture
    input wire upstream_count_input, // Up count
    input wire upstream_direction_input, // Up dir
    input wire toggle_latch_output_pin, // Toggle out
    input wire core_event_out // Wrap pulse
);
    reg out_en_reg;
    reg [3:0] cap_hist_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always @(posedge clk) begin
        cap_hist_reg <= {cap_hist_reg[2:0], capture_input_pin};
        if (!rst_n) begin
            out_en_reg <= 1'b0;
        end else if (wr && addr == 3'h1) begin
            out_en_reg <= wdata[11];
        end
    end
    ////////////////////////////////////////////////////////////////
    // Software may move the latch or enable itself
    sequence quiet_bus;
        !wr && !$past(wr) && !$past(wr, 2);
    endsequence
    a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    a_unmapped_reads_zero: assert property (rd && addr == 3'h7 |=> rdata == 16'h0000)
        else $error("unmapped index read not zero");
    a_reset_quiet_outputs: assert property (disable iff (1'b0) !rst_n |=> !core_event_out && !toggle_latch_output_pin)
        else $error("outputs active after reset");
    a_event_single_pulse: assert property (core_event_out |=> !core_event_out)
        else $error("wrap pulse longer than one cycle");
    a_pin_needs_event: assert property ($changed(toggle_latch_output_pin) ##0 quiet_bus |-> $past(core_event_out))
        else $error("toggle pin moved without wrap");
    a_event_moves_pin: assert property (core_event_out && out_en_reg ##0 quiet_bus |=> $changed(toggle_latch_output_pin))
        else $error("wrap did not move toggle pin");
    a_status_latch_pin: assert property (rd && addr == 3'h6 && out_en_reg ##0 quiet_bus |=> rdata[0] == toggle_latch_output_pin)
        else $error("status latch bit differs from pin");
    a_status_sync_cap: assert property (rd && addr == 3'h6 && (cap_hist_reg == 4'h0 || cap_hist_reg == 4'hF)
        |=> rdata[4] == $past(cap_hist_reg[0]))
        else $error("status capture level wrong");
endmodule
bind stu_timer_unit stu_timer_checker u_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .aux_count_pin(aux_count_pin), .core_count_pin(core_count_pin), .aux_dir_pin(aux_dir_pin),
    .core_dir_pin(core_dir_pin), .capture_input_pin(capture_input_pin), .upstream_count_input(upstream_count_input),
    .upstream_direction_input(upstream_direction_input), .toggle_latch_output_pin(toggle_latch_output_pin),
    .core_event_out(core_event_out));

// ### stu_pin_model.sv
`timescale 1ns/1ps
module stu_pin_model (
    input wire clk, // System clock
    output reg [6:0] pin // Count, dir, capture, upstream pins
);
    initial pin = 7'h00;
    task pulse(input integer idx, input integer cnt, input integer gap);
        integer i;
        begin
            for (i = 0; i < 2 * cnt; i = i + 1) begin
                @(posedge clk);
                pin[idx] <= ~pin[idx];
                repeat (gap) @(posedge clk);
            end
        end
    endtask
    task level(input integer idx, input reg lvl);
        begin
            @(posedge clk);
            pin[idx] <= lvl;
        end
    endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [2:0] addr = 3'h0;
    reg [15:0] wdata = 16'h0000;
    reg wr = 1'b0;
    reg rd = 1'b0;
    wire [15:0] rdata;
    wire [6:0] p;
    wire tog;
    wire evt;
    reg [15:0] v;
    integer n;
    integer k;
    integer n_evt = 0;
    integer n_fail = 0;
    integer checks = 0;
    stu_timer_unit DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .aux_count_pin(p[0]), .core_count_pin(p[1]), .aux_dir_pin(p[2]), .core_dir_pin(p[3]),
        .capture_input_pin(p[4]), .upstream_count_input(p[5]), .upstream_direction_input(p[6]),
        .toggle_latch_output_pin(tog), .core_event_out(evt));
    stu_pin_model pins (.clk(clk), .pin(p));
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (evt === 1'b1) n_evt <= n_evt + 1;
    ////////////////////////////////////////////////////////////////
    task wr_reg(input [2:0] a, input [15:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [2:0] a);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 v = rdata;
        end
    endtask
    task chk(input [8*8-1:0] nm, input [15:0] lo, input [15:0] hi, input [15:0] got);
        begin
            checks = checks + 1;
            if (^got === 1'bx || got < lo || got > hi) begin
                n_fail = n_fail + 1;
                $display("FAIL %0s expected %h..%h seen %h", nm, lo, hi, got);
            end
        end
    endtask
    task wait_evt;
        begin
            n = 0;
            do begin
                @(posedge clk);
                #1 n = n + 1;
            end while (evt !== 1'b1 && n < 200);
        end
    endtask
    task conclude;
        begin
            if (n_fail == 0 && checks > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task s_regs;
        begin
            rd_reg(3'h1);
            chk("ctrl", 16'h0000, 16'h0000, v);
            wr_reg(3'h5, 16'h0021);
            rd_reg(3'h5);
            chk("capctrl", 16'h0021, 16'h0021, v);
            wr_reg(3'h7, 16'hFFFF);
            rd_reg(3'h7);
            chk("unmapped", 16'h0000, 16'h0000, v);
            wr_reg(3'h5, 16'h0000);
        end
    endtask
    task s_prescale;
        begin
            wr_reg(3'h3, 16'h0000);
            wr_reg(3'h1, 16'h0020);
            repeat (40) @(posedge clk);
            wr_reg(3'h1, 16'h0000);
            rd_reg(3'h3);
            chk("div2", 16'd20, 16'd22, v);
            wr_reg(3'h3, 16'h0000);
            wr_reg(3'h1, 16'h0022);
            repeat (80) @(posedge clk);
            wr_reg(3'h1, 16'h0000);
            rd_reg(3'h3);
            chk("div8", 16'd9, 16'd11, v);
        end
    endtask
    task s_wrap;
        begin
            wr_reg(3'h4, 16'hFFF0);
            wr_reg(3'h3, 16'hFFFE);
            wr_reg(3'h1, 16'h0C20);
            wait_evt;
            // Pin follows the latch one clock late
            @(posedge clk);
            #1;
            chk("tog_up", 16'h0001, 16'h0001, {15'h0000, tog});
            wait_evt;
            // Sixteen ticks of two clocks, less the edge spent above
            chk("period", 16'd31, 16'd31, n[15:0]);
            @(posedge clk);
            #1;
            chk("tog_dn", 16'h0000, 16'h0000, {15'h0000, tog});
            rd_reg(3'h6);
            chk("latch", 16'h0000, 16'h0000, {15'h0000, v[0]});
            wr_reg(3'h1, 16'h0000);
            rd_reg(3'h3);
            chk("reload", 16'hFFF0, 16'hFFF3, v);
        end
    endtask
    task s_direction;
        begin
            wr_reg(3'h3, 16'h0001);
            wr_reg(3'h1, 16'h0060);
            wait_evt;
            chk("under", 16'd1, 16'd6, n[15:0]);
            pins.level(3, 1'b1);
            wr_reg(3'h3, 16'h0100);
            wr_reg(3'h1, 16'h00A0);
            repeat (40) @(posedge clk);
            wr_reg(3'h1, 16'h0000);
            rd_reg(3'h3);
            chk("pindown", 16'h00EA, 16'h00ED, v);
            pins.level(3, 1'b0);
        end
    endtask
    task s_ext_clock;
        begin
            wr_reg(3'h2, 16'h0000);
            wr_reg(3'h0, 16'h0128);
            pins.pulse(0, 5, 3);
            pins.pulse(2, 1, 0);
            wr_reg(3'h0, 16'h0328);
            pins.pulse(0, 4, 1);
            repeat (6) @(posedge clk);
            wr_reg(3'h0, 16'h0000);
            rd_reg(3'h2);
            chk("auxpin", 16'd13, 16'd13, v);
            wr_reg(3'h3, 16'h0000);
            wr_reg(3'h1, 16'h0228);
            pins.pulse(1, 3, 2);
            repeat (6) @(posedge clk);
            wr_reg(3'h1, 16'h0000);
            rd_reg(3'h3);
            chk("corepin", 16'd3, 16'd3, v);
        end
    endtask
    task s_toggle_clock;
        begin
            wr_reg(3'h2, 16'h0000);
            wr_reg(3'h0, 16'h0330);
            wr_reg(3'h4, 16'hFFFF);
            wr_reg(3'h3, 16'hFFFF);
            n_evt = 0;
            wr_reg(3'h1, 16'h0420);
            repeat (40) @(posedge clk);
            wr_reg(3'h1, 16'h0000);
            repeat (6) @(posedge clk);
            wr_reg(3'h0, 16'h0000);
            chk("events", 16'd15, 16'd25, n_evt[15:0]);
            rd_reg(3'h2);
            chk("auxtog", n_evt[15:0], n_evt[15:0], v);
        end
    endtask
    task s_capture;
        begin
            wr_reg(3'h5, 16'h0025);
            wr_reg(3'h2, 16'h0000);
            wr_reg(3'h0, 16'h0020);
            repeat (30) @(posedge clk);
            pins.pulse(4, 1, 10);
            rd_reg(3'h4);
            chk("capture", 16'd10, 16'd30, v);
            rd_reg(3'h2);
            chk("cleared", 16'd0, 16'd15, v);
            for (k = 0; k < 2; k = k + 1) begin
                wr_reg(3'h5, 16'h0008 << k);
                wr_reg(3'h4, 16'h0000);
                pins.pulse(6 - k, 1, 6);
                rd_reg(3'h4);
                chk("up_off", 16'h0000, 16'h0000, v);
                pins.pulse(5 + k, 1, 6);
                rd_reg(3'h4);
                chk("up_on", 16'h0001, 16'hFFFF, v);
            end
            wr_reg(3'h0, 16'h0000);
            pins.level(4, 1'b1);
            repeat (8) @(posedge clk);
            rd_reg(3'h6);
            chk("caplevel", 16'h0001, 16'h0001, {15'h0000, v[4]});
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        s_regs;
        s_prescale;
        s_wrap;
        s_direction;
        s_ext_clock;
        s_toggle_clock;
        s_capture;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail = n_fail + 1;
        conclude;
    end
endmodule
